// ===== include/tmr_pkg.sv
// shared constants and types for the timer waveform control block
`default_nettype none
package tmr_pkg;
   // register byte offsets on the bus
   localparam logic [7:0] OFS_CTRL_A = 8'h00;
   localparam logic [7:0] OFS_CTRL_B = 8'h04;
   localparam logic [7:0] OFS_COUNT = 8'h08;
   localparam logic [7:0] OFS_CMP_A = 8'h0c;
   localparam logic [7:0] OFS_CMP_B = 8'h10;
   localparam logic [7:0] OFS_FLAGS = 8'h14;
   localparam logic [7:0] OFS_PORT = 8'h18;
   localparam logic [7:0] OFS_GEN = 8'h2c;
   // reset values
   localparam logic [7:0] RST_CTRL_A = 8'h00;
   localparam logic [7:0] RST_CTRL_B = 8'h00;
   localparam logic [7:0] RST_GEN = 8'h00;
   localparam logic [3:0] RST_PORT = 4'h0;
   // writable bit masks; everything else reads as zero
   localparam logic [7:0] CTRL_A_MASK = 8'hf3;
   localparam logic [7:0] CTRL_B_MASK = 8'h0f;
   // field positions
   localparam int GEN_SYNC_BIT = 7;
   localparam int GEN_PSR_BIT = 0;
   localparam int CA_OM_A_LO = 6;
   localparam int CA_WM_LO = 0;
   localparam int CB_FORCE_A = 7;
   localparam int CB_WM_HIGH = 3;
   localparam int CB_CS_LO = 0;
   localparam int FLG_MATCH_A = 4;
   localparam int FLG_OVF = 1;
   localparam int PORT_DIR_A = 0;
   localparam int PORT_DATA_A = 2;
   // count limits
   localparam logic [7:0] MAX_VAL = 8'hff;
   localparam logic [7:0] BOTTOM_VAL = 8'h00;
   // clock select codes
   localparam logic [2:0] CS_STOP = 3'h0;
   localparam logic [2:0] CS_DIV1 = 3'h1;
   localparam logic [2:0] CS_DIV8 = 3'h2;
   localparam logic [2:0] CS_DIV64 = 3'h3;
   localparam logic [2:0] CS_DIV256 = 3'h4;
   localparam logic [2:0] CS_DIV1024 = 3'h5;
   localparam logic [2:0] CS_EXT_FALL = 3'h6;
   localparam logic [2:0] CS_EXT_RISE = 3'h7;
   // prescaler tap widths: divide by two to the power of these
   localparam int DIV8_BITS = 3;
   localparam int DIV64_BITS = 6;
   localparam int DIV256_BITS = 8;
   localparam int DIV1024_BITS = 10;
   // waveform mode codes
   localparam logic [2:0] WM_NORMAL = 3'h0;
   localparam logic [2:0] WM_PC_MAX = 3'h1;
   localparam logic [2:0] WM_CTC = 3'h2;
   localparam logic [2:0] WM_FAST_MAX = 3'h3;
   localparam logic [2:0] WM_PC_A = 3'h5;
   localparam logic [2:0] WM_FAST_A = 3'h7;
   // output mode codes
   localparam logic [1:0] OM_OFF = 2'h0;
   localparam logic [1:0] OM_TOGGLE = 2'h1;
   localparam logic [1:0] OM_CLEAR = 2'h2;
   localparam logic [1:0] OM_SET = 2'h3;

   typedef enum logic [2:0] {TMR_NORMAL, TMR_CTC, TMR_FAST, TMR_PC, TMR_RSVD} tmr_kind_e;

   // captured address phase of a bus transfer
   typedef struct packed {
      logic act;
      logic wr;
      logic [7:0] addr;
   } tmr_aphase_s;
endpackage
`default_nettype wire

// ===== rtl/tmr_prescaler.sv
// prescaler that turns the i/o clock into the timer tick enable
`timescale 1ns/100ps
`default_nettype none
module tmr_prescaler
   import tmr_pkg::*;
#(
   parameter int PW = DIV1024_BITS
) (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_clr,
   input wire logic [2:0] i_sel,
   input wire logic i_ext,
   output logic o_tick
);
   logic [PW-1:0] cnt_r;
   logic [PW-1:0] cnt_nxt;
   logic ext_r;
   logic tick_nxt;

   // the widest tap must fit in the divider
   if (PW < DIV1024_BITS) begin : g_chk
      $error("tmr_prescaler: PW too small for divide by 1024");
   end

   // tap select; a held clear also swallows external edges
   always_comb begin
      cnt_nxt = i_clr ? '0 : cnt_r + PW'(1);
      unique case (i_sel)
         CS_STOP: tick_nxt = 1'b0;
         CS_DIV1: tick_nxt = 1'b1;
         CS_DIV8: tick_nxt = &cnt_r[DIV8_BITS-1:0];
         CS_DIV64: tick_nxt = &cnt_r[DIV64_BITS-1:0];
         CS_DIV256: tick_nxt = &cnt_r[DIV256_BITS-1:0];
         CS_DIV1024: tick_nxt = &cnt_r[DIV1024_BITS-1:0];
         CS_EXT_FALL: tick_nxt = ext_r & ~i_ext;
         CS_EXT_RISE: tick_nxt = ~ext_r & i_ext;
      endcase
      if (i_clr) begin
         tick_nxt = 1'b0;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         cnt_r <= '0;
         ext_r <= 1'b0;
      end else begin
         cnt_r <= cnt_nxt;
         ext_r <= i_ext;
      end
   end

   // tick is an enable in the i/o clock domain, never a clock
   assign o_tick = tick_nxt;
endmodule
`default_nettype wire

// ===== rtl/tmr_waveform_top.sv
// timer waveform control: counter, compare channels, pins, AHB-Lite registers
//
// Implementation choice: the AHB-Lite slave port.
`timescale 1ns/100ps
`default_nettype none
// Notes on behaviour
// [R01] all logic on i/o clock, tick is enable
// [R02] sync hold keeps prescaler reset bit asserted
// [R03] sync cleared: reset bit cleared, counting resumes
// [R04] reset bit resets prescaler, self-clears unless held
// [R05] nonzero output mode puts waveform on pin
// [R06] pin driven only when direction bit set
// [R07] non-pwm codes: off, toggle, clear, set
// [R08] fast pwm: off, reserved, non-inverting, inverting
// [R09] fast pwm compare equals top: bottom action only
// [R10] phase pwm: clear up, set down, inverted
// [R11] phase pwm compare equals top: action at top
// [R12] control a bits 3:2 read zero
// [R13] three-bit mode picks sequence, top, waveform
// [R14] normal and ctc: immediate update, overflow at max
// [R15] phase modes: update at top, overflow at bottom
// [R16] fast modes: update at bottom, overflow max/top
// [R17] compare-a top: flag a set, counter cleared except in phase pwm
// [R18] match flags set on matches, every mode
// [R19] clock select: stop, prescale taps, external edges
// [R20] modes 4 and 6 freeze the counter
// [R21] flags set on tick after matching value
module tmr_waveform_top
   import tmr_pkg::*;
#(
   parameter int PRESCALE_W = DIV1024_BITS
) (
   input wire logic I_SYS_CLK,
   input wire logic I_SRST,
   input wire logic I_HSEL,
   input wire logic [31:0] I_HADDR,
   input wire logic [1:0] I_HTRANS,
   input wire logic I_HWRITE,
   input wire logic [2:0] I_HSIZE,
   input wire logic [31:0] I_HWDATA,
   input wire logic I_HREADY,
   input wire logic I_EXT_COUNT,
   output logic [31:0] O_HRDATA,
   output logic O_HREADYOUT,
   output logic O_HRESP,
   output logic O_PIN_A,
   output logic O_PIN_A_OE,
   output logic O_PIN_B,
   output logic O_PIN_B_OE
);
   // decoding shared by every register write; reads decode the address with their own case
   function automatic logic hit(input tmr_aphase_s ap, input logic [7:0] ofs);
      return ap.act && (ap.addr == ofs);
   endfunction

   function automatic tmr_kind_e kind_of(input logic [2:0] wm);
      unique case (wm)
         WM_NORMAL: kind_of = TMR_NORMAL;
         WM_CTC: kind_of = TMR_CTC;
         WM_FAST_MAX, WM_FAST_A: kind_of = TMR_FAST;
         WM_PC_MAX, WM_PC_A: kind_of = TMR_PC;
         default: kind_of = TMR_RSVD;
      endcase
   endfunction

   tmr_aphase_s ap_r;
   tmr_aphase_s ap_nxt;
   logic [31:0] rd_r;
   logic [31:0] rd_nxt;
   logic [7:0] ctrl_a_r, ctrl_a_nxt, ctrl_b_r, ctrl_b_nxt;
   logic [3:0] port_r, port_nxt;
   logic sync_r, sync_nxt, psr_r, psr_nxt;
   logic [7:0] cnt_r, cnt_nxt;
   logic up_r, up_nxt, blk_r, blk_nxt, ovf_r, ovf_nxt;
   logic [7:0] wdata8;
   logic wr_ca, wr_cb, wr_cnt, wr_flg, wr_port, wr_gen;
   logic pre_tick, tick, at_top, ovf_ev;
   logic [2:0] wm;
   tmr_kind_e kind;
   logic [7:0] top;
   logic [7:0] cmp_act_w [2];
   logic [7:0] cmp_buf_w [2];
   logic mflag_w [2];
   logic pin_w [2];
   logic oe_w [2];

   // register writes happen in the data phase of the captured address
   assign wdata8 = I_HWDATA[7:0];
   assign wr_ca = hit(ap_r, OFS_CTRL_A) & ap_r.wr;
   assign wr_cb = hit(ap_r, OFS_CTRL_B) & ap_r.wr;
   assign wr_cnt = hit(ap_r, OFS_COUNT) & ap_r.wr;
   assign wr_flg = hit(ap_r, OFS_FLAGS) & ap_r.wr;
   assign wr_port = hit(ap_r, OFS_PORT) & ap_r.wr;
   assign wr_gen = hit(ap_r, OFS_GEN) & ap_r.wr;

   // bus slave: zero wait states, read data fetched at the address phase
   always_comb begin
      ap_nxt.act = I_HSEL & I_HTRANS[1] & I_HREADY & (I_HADDR[1:0] == 2'b00);
      ap_nxt.wr = I_HWRITE;
      ap_nxt.addr = I_HADDR[7:0];
      rd_nxt = '0;
      if (ap_nxt.act && !I_HWRITE) begin
         case (ap_nxt.addr)
            // [R12] reserved bits zero
            OFS_CTRL_A: rd_nxt = {24'h0, ctrl_a_r & CTRL_A_MASK};
            OFS_CTRL_B: rd_nxt = {24'h0, ctrl_b_r & CTRL_B_MASK};
            OFS_COUNT: rd_nxt = {24'h0, cnt_r};
            OFS_CMP_A: rd_nxt = {24'h0, cmp_buf_w[0]};
            OFS_CMP_B: rd_nxt = {24'h0, cmp_buf_w[1]};
            OFS_FLAGS: rd_nxt = {27'h0, mflag_w[0], mflag_w[1], 1'b0, ovf_r, 1'b0};
            OFS_PORT: rd_nxt = {28'h0, port_r};
            OFS_GEN: rd_nxt = {24'h0, sync_r, 6'h00, psr_r};
            default: rd_nxt = '0;
         endcase
      end
   end

   always_ff @(posedge I_SYS_CLK) begin
      if (I_SRST) begin
         ap_r <= '0;
         rd_r <= '0;
      end else begin
         ap_r <= ap_nxt;
         rd_r <= rd_nxt;
      end
   end

   // answer is always ready and okay; the size field is not checked
   always_ff @(posedge I_SYS_CLK) begin
      if (I_SRST) begin
         O_HREADYOUT <= 1'b1;
         O_HRESP <= 1'b0;
      end else begin
         O_HREADYOUT <= 1'b1;
         O_HRESP <= 1'b0;
      end
   end
   assign O_HRDATA = rd_r;

   // control registers and the prescaler reset handshake
   always_comb begin
      ctrl_a_nxt = wr_ca ? (wdata8 & CTRL_A_MASK) : ctrl_a_r;
      ctrl_b_nxt = wr_cb ? (wdata8 & CTRL_B_MASK) : ctrl_b_r;
      port_nxt = wr_port ? wdata8[3:0] : port_r;
      sync_nxt = sync_r;
      // [R04] self-clear unless held
      psr_nxt = sync_r ? psr_r : 1'b0;
      if (wr_gen) begin
         // [R02] sync hold keeps it
         sync_nxt = wdata8[GEN_SYNC_BIT];
         psr_nxt = wdata8[GEN_PSR_BIT];
      end
   end

   always_ff @(posedge I_SYS_CLK) begin
      if (I_SRST) begin
         ctrl_a_r <= RST_CTRL_A;
         ctrl_b_r <= RST_CTRL_B;
         port_r <= RST_PORT;
         sync_r <= RST_GEN[GEN_SYNC_BIT];
         psr_r <= RST_GEN[GEN_PSR_BIT];
      end else begin
         ctrl_a_r <= ctrl_a_nxt;
         ctrl_b_r <= ctrl_b_nxt;
         port_r <= port_nxt;
         sync_r <= sync_nxt;
         psr_r <= psr_nxt;
      end
   end

   // [R19] clock select taps
   tmr_prescaler #(
      .PW(PRESCALE_W)
   ) u_prescaler (
      .i_clk(I_SYS_CLK),
      .i_rst(I_SRST),
      .i_clr(psr_r),
      .i_sel(ctrl_b_r[CB_CS_LO +: 3]),
      .i_ext(I_EXT_COUNT),
      .o_tick(pre_tick)
   );

   // [R13] mode code and top source
   assign wm = {ctrl_b_r[CB_WM_HIGH], ctrl_a_r[CA_WM_LO +: 2]};
   assign kind = kind_of(wm);
   assign top = (wm == WM_CTC || wm == WM_PC_A || wm == WM_FAST_A) ? cmp_act_w[0] : MAX_VAL;
   // [R20] reserved modes freeze
   assign tick = pre_tick & (kind != TMR_RSVD);
   assign at_top = (cnt_r == top);

   // overflow event per mode, one tick after the value is seen
   always_comb begin
      ovf_ev = 1'b0;
      unique case (kind)
         // [R14] normal and ctc at max
         TMR_NORMAL, TMR_CTC: ovf_ev = tick & (cnt_r == MAX_VAL);
         // [R16] fast at max or top
         TMR_FAST: ovf_ev = tick & ((wm == WM_FAST_A) ? at_top : (cnt_r == MAX_VAL));
         // [R15] phase at bottom
         TMR_PC: ovf_ev = tick & ~up_r & (cnt_r == BOTTOM_VAL);
         TMR_RSVD: ovf_ev = 1'b0;
      endcase
   end

   // counter: ticks act as enable, a software write wins and blocks one match
   always_comb begin
      cnt_nxt = cnt_r;
      up_nxt = up_r;
      blk_nxt = blk_r;
      // [R01] tick as enable
      if (tick) begin
         blk_nxt = 1'b0;
         unique case (kind)
            TMR_NORMAL: cnt_nxt = cnt_r + 8'h01;
            // [R17] clear at top
            TMR_CTC, TMR_FAST: cnt_nxt = at_top ? BOTTOM_VAL : cnt_r + 8'h01;
            TMR_PC: begin
               if (up_r && at_top) begin
                  up_nxt = 1'b0;
                  cnt_nxt = cnt_r - 8'h01;
               end else if (!up_r && cnt_r == BOTTOM_VAL) begin
                  up_nxt = 1'b1;
                  cnt_nxt = cnt_r + 8'h01;
               end else begin
                  cnt_nxt = up_r ? cnt_r + 8'h01 : cnt_r - 8'h01;
               end
            end
            TMR_RSVD: cnt_nxt = cnt_r;
         endcase
      end
      if (wr_cnt) begin
         cnt_nxt = wdata8;
         blk_nxt = 1'b1;
      end
      // [R21] overflow flag, set beats clear
      ovf_nxt = ovf_ev | (ovf_r & ~(wr_flg & wdata8[FLG_OVF]));
   end

   always_ff @(posedge I_SYS_CLK) begin
      if (I_SRST) begin
         cnt_r <= BOTTOM_VAL;
         up_r <= 1'b1;
         blk_r <= 1'b0;
         ovf_r <= 1'b0;
      end else begin
         cnt_r <= cnt_nxt;
         up_r <= up_nxt;
         blk_r <= blk_nxt;
         ovf_r <= ovf_nxt;
      end
   end

   // one compare channel each: buffer, active value, flag, waveform and pin
   for (genvar i = 0; i < 2; i++) begin : g_ch
      localparam logic [7:0] CMP_OFS = (i == 0) ? OFS_CMP_A : OFS_CMP_B;
      logic [7:0] buf_r, buf_nxt, act_r, act_nxt;
      logic flag_r, flag_nxt, wave_r, wave_nxt, pin_r, pin_nxt, oe_r, oe_nxt;
      logic [1:0] om;
      logic match, special, force_ev;

      assign om = ctrl_a_r[CA_OM_A_LO - 2*i +: 2];
      assign match = tick & ~blk_r & (cnt_r == act_r);
      assign special = om[1] & (act_r == top);
      assign force_ev = wr_cb & wdata8[CB_FORCE_A - i] & (kind == TMR_NORMAL || kind == TMR_CTC);

      always_comb begin
         buf_nxt = (hit(ap_r, CMP_OFS) & ap_r.wr) ? wdata8 : buf_r;
         act_nxt = act_r;
         // [R14] immediate update
         if (kind == TMR_NORMAL || kind == TMR_CTC) begin
            act_nxt = buf_nxt;
         // [R15] [R16] update at top or bottom
         end else if ((kind == TMR_PC || kind == TMR_FAST) && tick && at_top) begin
            act_nxt = buf_r;
         end
         // [R18] match flag, set beats clear
         flag_nxt = match | (flag_r & ~(wr_flg & wdata8[FLG_MATCH_A - i]));
         wave_nxt = wave_r;
         unique case (kind)
            // [R07] non-pwm actions
            TMR_NORMAL, TMR_CTC: begin
               if (match || force_ev) begin
                  unique case (om)
                     OM_OFF: wave_nxt = wave_r;
                     OM_TOGGLE: wave_nxt = ~wave_r;
                     OM_CLEAR: wave_nxt = 1'b0;
                     OM_SET: wave_nxt = 1'b1;
                  endcase
               end
            end
            TMR_FAST: begin
               // [R08] match then bottom
               if (match && om[1] && !special) begin
                  wave_nxt = om[0];
               end
               // [R09] bottom still acts
               if (tick && at_top && om[1]) begin
                  wave_nxt = ~om[0];
               end
            end
            TMR_PC: begin
               // [R10] direction decides
               // the direction after the tick is used, so a match at the bottom turn
               // counts as up-counting and a zero compare keeps the output steady
               if (match && om[1] && !special) begin
                  wave_nxt = up_nxt ? om[0] : ~om[0];
               end
               // [R11] action at top
               if (special && tick && at_top && up_r) begin
                  wave_nxt = ~om[0];
               end
            end
            TMR_RSVD: wave_nxt = wave_r;
         endcase
         // [R05] waveform overrides port data
         pin_nxt = (om != OM_OFF) ? wave_nxt : port_r[PORT_DATA_A + i];
         // [R06] driver follows direction
         oe_nxt = port_r[PORT_DIR_A + i];
      end

      always_ff @(posedge I_SYS_CLK) begin
         if (I_SRST) begin
            buf_r <= BOTTOM_VAL;
            act_r <= BOTTOM_VAL;
            flag_r <= 1'b0;
            wave_r <= 1'b0;
            pin_r <= 1'b0;
            oe_r <= 1'b0;
         end else begin
            buf_r <= buf_nxt;
            act_r <= act_nxt;
            flag_r <= flag_nxt;
            wave_r <= wave_nxt;
            pin_r <= pin_nxt;
            oe_r <= oe_nxt;
         end
      end

      assign cmp_act_w[i] = act_r;
      assign cmp_buf_w[i] = buf_r;
      assign mflag_w[i] = flag_r;
      assign pin_w[i] = pin_r;
      assign oe_w[i] = oe_r;
   end

   // pins come straight from the channel flip-flops
   assign O_PIN_A = pin_w[0];
   assign O_PIN_A_OE = oe_w[0];
   assign O_PIN_B = pin_w[1];
   assign O_PIN_B_OE = oe_w[1];

   // checks on the documented behaviour
   property p_psr_pulse;
      @(posedge I_SYS_CLK) disable iff (I_SRST)
         wr_gen && !wdata8[GEN_SYNC_BIT] && wdata8[GEN_PSR_BIT] |=> psr_r ##1 !psr_r;
   endproperty
   a_psr_pulse: assert property (p_psr_pulse) // [R04]
      else $error("prescaler reset bit did not self-clear");

   property p_sync_hold;
      @(posedge I_SYS_CLK) disable iff (I_SRST)
         sync_r && psr_r && !wr_gen |=> psr_r;
   endproperty
   a_sync_hold: assert property (p_sync_hold) // [R02]
      else $error("prescaler reset bit dropped under sync hold");

   property p_sync_release;
      @(posedge I_SYS_CLK) disable iff (I_SRST)
         wr_gen && !wdata8[GEN_SYNC_BIT] |=> !sync_r ##1 (!psr_r || wr_gen);
   endproperty
   a_sync_release: assert property (p_sync_release) // [R03]
      else $error("prescaler reset bit not cleared on sync release");

   property p_halted;
      @(posedge I_SYS_CLK) disable iff (I_SRST)
         psr_r && !wr_cnt |=> $stable(cnt_r);
   endproperty
   a_halted: assert property (p_halted) // [R01]
      else $error("counter advanced while prescaler held in reset");

   property p_rsvd_read;
      @(posedge I_SYS_CLK) disable iff (I_SRST)
         ap_nxt.act && !I_HWRITE && ap_nxt.addr == OFS_CTRL_A |=> O_HRDATA[3:2] == 2'b00;
   endproperty
   a_rsvd_read: assert property (p_rsvd_read) // [R12]
      else $error("reserved control bits read nonzero");

   property p_ovf_max;
      @(posedge I_SYS_CLK) disable iff (I_SRST)
         tick && kind == TMR_NORMAL && cnt_r == MAX_VAL |=> ovf_r && cnt_r == BOTTOM_VAL;
   endproperty
   a_ovf_max: assert property (p_ovf_max) // [R14]
      else $error("normal mode overflow flag not set at max");

   property p_ctc_clear;
      @(posedge I_SYS_CLK) disable iff (I_SRST)
         tick && wm == WM_CTC && !blk_r && cnt_r == cmp_act_w[0] && !wr_cnt
            |=> cnt_r == BOTTOM_VAL && mflag_w[0];
   endproperty
   a_ctc_clear: assert property (p_ctc_clear) // [R17]
      else $error("ctc top did not clear counter and set flag a");

   property p_pc_bottom;
      @(posedge I_SYS_CLK) disable iff (I_SRST)
         tick && kind == TMR_PC && !up_r && cnt_r == BOTTOM_VAL |=> ovf_r && up_r;
   endproperty
   a_pc_bottom: assert property (p_pc_bottom) // [R15]
      else $error("phase mode overflow not set at bottom");

   property p_pin_dir;
      @(posedge I_SYS_CLK) disable iff (I_SRST)
         $changed(port_r[PORT_DIR_A]) |=> O_PIN_A_OE == $past(port_r[PORT_DIR_A]);
   endproperty
   a_pin_dir: assert property (p_pin_dir) // [R06]
      else $error("pin a driver does not follow direction bit");

   property p_pin_port;
      @(posedge I_SYS_CLK) disable iff (I_SRST)
         ctrl_a_r[CA_OM_A_LO +: 2] == OM_OFF |=> O_PIN_A == $past(port_r[PORT_DATA_A]);
   endproperty
   a_pin_port: assert property (p_pin_port) // [R05]
      else $error("pin a not on port data while disconnected");

   property p_frozen;
      @(posedge I_SYS_CLK) disable iff (I_SRST)
         kind == TMR_RSVD && !wr_cnt |=> $stable(cnt_r);
   endproperty
   a_frozen: assert property (p_frozen) // [R20]
      else $error("counter moved in a reserved mode");
endmodule
`default_nettype wire

// ===== bench/tb.sv
// self-checking testbench for the timer waveform control block
`timescale 1ns/100ps
`default_nettype none
module tb
   import tmr_pkg::*;
;
   logic clk = 1'b0;
   logic srst = 1'b1;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0;
   logic ext = 1'b0;
   wire logic [31:0] hrdata;
   wire logic hready, hresp, pin_a, pin_a_oe, pin_b, pin_b_oe;
   int fail_count = 0;
   int check_count = 0;
   int lows;
   logic [31:0] rv;

   tmr_waveform_top #(.PRESCALE_W(DIV1024_BITS)) i_dut (.I_SYS_CLK(clk), .I_SRST(srst),
      .I_HSEL(hsel), .I_HADDR(haddr), .I_HTRANS(htrans), .I_HWRITE(hwrite),
      .I_HSIZE(3'h2), .I_HWDATA(hwdata), .I_HREADY(hready), .I_EXT_COUNT(ext),
      .O_HRDATA(hrdata), .O_HREADYOUT(hready), .O_HRESP(hresp), .O_PIN_A(pin_a),
      .O_PIN_A_OE(pin_a_oe), .O_PIN_B(pin_b), .O_PIN_B_OE(pin_b_oe));

   // 20 MHz clock
   initial begin
      forever #25 clk = ~clk;
   end

   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         fail_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // waits for hready at a rising edge; only the watchdog ends a stuck wait
   task automatic wait_ready;
      @(posedge clk);
      while (hready !== 1'b1) begin
         @(posedge clk);
      end
   endtask

   // one single AHB-Lite transfer; read data taken at the edge ending the data phase
   task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd,
         output logic [31:0] rd);
      @(posedge clk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {24'h0, a};
      hwrite <= wr;
      wait_ready();
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= wd;
      wait_ready();
      rd = hrdata;
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [31:0] x;
      xfer(1'b1, a, {24'h0, d}, x);
   endtask

   task automatic rd(input logic [7:0] a);
      xfer(1'b0, a, 32'h0, rv);
   endtask

   task automatic chk_reg(input logic [7:0] a, input logic [31:0] exp);
      rd(a);
      check(rv, exp);
   endtask

   task automatic setup(input logic [3:0] om, input logic [2:0] m, input logic [2:0] cs);
      wr(OFS_CTRL_A, {om, 2'h0, m[1:0]});
      wr(OFS_CTRL_B, {4'h0, m[2], cs});
   endtask

   task automatic idle(input int n);
      repeat (n) @(posedge clk);
   endtask

   // external pin pulses, each giving one rise and one fall
   task automatic pulses(input int n);
      repeat (n) begin
         @(posedge clk);
         ext <= 1'b1;
         idle(3);
         ext <= 1'b0;
         idle(3);
      end
   endtask

   task automatic count_lows(input int n);
      lows = 0;
      repeat (n) begin
         @(posedge clk);
         if (pin_a !== 1'b1) lows++;
      end
   endtask

   task automatic t_regs;
      chk_reg(OFS_CTRL_A, 32'h0);
      chk_reg(OFS_GEN, 32'h0);
      chk_reg(OFS_FLAGS, 32'h0);
      wr(OFS_CTRL_A, 8'hff);
      chk_reg(OFS_CTRL_A, 32'hf3);
      wr(OFS_CTRL_A, 8'h00);
      wr(8'h30, 8'h5a);
      chk_reg(8'h30, 32'h0);
      check({31'h0, hresp}, 32'h0);
      check({31'h0, hready}, 32'h1);
      $display("test regs done");
   endtask

   task automatic t_psr;
      setup(4'h0, WM_NORMAL, CS_DIV1);
      wr(OFS_GEN, 8'h01);
      chk_reg(OFS_GEN, 32'h0);
      wr(OFS_GEN, 8'h81);
      chk_reg(OFS_GEN, 32'h81);
      wr(OFS_COUNT, 8'h10);
      idle(20);
      chk_reg(OFS_COUNT, 32'h10);
      wr(OFS_GEN, 8'h00);
      chk_reg(OFS_GEN, 32'h0);
      rd(OFS_COUNT);
      check(32'(rv > 32'h10), 32'h1);
      $display("test prescaler reset done");
   endtask

   task automatic t_ext;
      setup(4'h0, WM_NORMAL, CS_STOP);
      wr(OFS_COUNT, 8'h00);
      setup(4'h0, WM_NORMAL, CS_EXT_RISE);
      pulses(5);
      chk_reg(OFS_COUNT, 32'h5);
      setup(4'h0, WM_NORMAL, CS_EXT_FALL);
      pulses(5);
      chk_reg(OFS_COUNT, 32'ha);
      $display("test external clock done");
   endtask

   task automatic t_ovf;
      setup(4'h0, WM_NORMAL, CS_STOP);
      wr(OFS_COUNT, 8'hf0);
      wr(OFS_FLAGS, 8'h1a);
      setup(4'h0, WM_NORMAL, CS_DIV1);
      idle(40);
      setup(4'h0, WM_NORMAL, CS_STOP);
      rd(OFS_FLAGS);
      check(rv & 32'h2, 32'h2);
      wr(OFS_FLAGS, 8'h1a);
      chk_reg(OFS_FLAGS, 32'h0);
      $display("test overflow done");
   endtask

   // both channels set on match in clear-on-match mode, pins enabled
   task automatic t_ctc;
      setup(4'h0, WM_CTC, CS_STOP);
      wr(OFS_CMP_A, 8'h10);
      wr(OFS_CMP_B, 8'h08);
      wr(OFS_COUNT, 8'h00);
      wr(OFS_FLAGS, 8'h1a);
      wr(OFS_PORT, 8'h03);
      setup(4'hf, WM_CTC, CS_DIV1);
      idle(60);
      rd(OFS_COUNT);
      check(32'(rv <= 32'h10), 32'h1);
      rd(OFS_FLAGS);
      check(rv & 32'h1a, 32'h18);
      check({31'h0, pin_a}, 32'h1);
      check({31'h0, pin_b}, 32'h1);
      check({31'h0, pin_a_oe}, 32'h1);
      check({31'h0, pin_b_oe}, 32'h1);
      wr(OFS_PORT, 8'h00);
      idle(2);
      check({31'h0, pin_a_oe}, 32'h0);
      check({31'h0, pin_b_oe}, 32'h0);
      setup(4'h0, WM_CTC, CS_STOP);
      wr(OFS_PORT, 8'h05);
      idle(2);
      check({31'h0, pin_a}, 32'h1);
      $display("test clear on match done");
   endtask

   // boundary compare values where the pwm output must stay constant
   task automatic t_pwm;
      wr(OFS_PORT, 8'h01);
      wr(OFS_CMP_A, 8'hff);
      setup(4'h8, WM_FAST_MAX, CS_DIV1);
      idle(300);
      count_lows(600);
      check(32'(lows), 32'h0);
      rd(OFS_FLAGS);
      check(rv & 32'h2, 32'h2);
      wr(OFS_CMP_A, 8'h00);
      setup(4'h8, WM_PC_MAX, CS_DIV1);
      idle(600);
      count_lows(600);
      check(32'(lows), 32'd600);
      wr(OFS_CMP_A, 8'hff);
      // new compare loads at one top and acts at the next: up to two periods
      idle(1100);
      count_lows(600);
      check(32'(lows), 32'h0);
      $display("test pwm done");
   endtask

   task automatic t_topa;
      logic [2:0] ml [2];
      ml = '{WM_PC_A, WM_FAST_A};
      foreach (ml[i]) begin
         setup(4'h0, ml[i], CS_STOP);
         wr(OFS_COUNT, 8'h00);
         wr(OFS_CMP_A, 8'h20);
         wr(OFS_FLAGS, 8'h1a);
         setup(4'h0, ml[i], CS_DIV1);
         idle(700);
         rd(OFS_COUNT);
         check(32'(rv <= 32'h20), 32'h1);
         rd(OFS_FLAGS);
         check(rv & 32'h2, 32'h2);
      end
      $display("test compare top done");
   endtask

   // reserved mode codes keep the counter still
   task automatic t_frz;
      logic [2:0] ml [2];
      ml = '{3'h4, 3'h6};
      foreach (ml[i]) begin
         setup(4'h0, ml[i], CS_STOP);
         wr(OFS_COUNT, 8'h55);
         wr(OFS_FLAGS, 8'h1a);
         setup(4'h0, ml[i], CS_DIV1);
         idle(30);
         chk_reg(OFS_COUNT, 32'h55);
         chk_reg(OFS_FLAGS, 32'h0);
      end
      $display("test reserved modes done");
   endtask

   // force strobe toggles pin a; divide by 8 from a synchronised start
   task automatic t_tgl;
      logic v;
      setup(4'h4, WM_NORMAL, CS_STOP);
      wr(OFS_PORT, 8'h01);
      idle(2);
      v = pin_a;
      wr(OFS_CTRL_B, {1'b1, 4'h0, CS_STOP});
      idle(2);
      check({31'h0, pin_a}, {31'h0, ~v});
      wr(OFS_GEN, 8'h81);
      wr(OFS_COUNT, 8'h00);
      setup(4'h0, WM_NORMAL, CS_DIV8);
      wr(OFS_GEN, 8'h00);
      idle(62);
      chk_reg(OFS_COUNT, 32'h7);
      $display("test toggle and divider done");
   endtask

   // main sequence
   initial begin
      idle(5);
      srst <= 1'b0;
      t_regs();
      t_psr();
      t_ext();
      t_ovf();
      t_ctc();
      t_pwm();
      t_topa();
      t_frz();
      t_tgl();
      tally_and_finish();
   end

   // watchdog well beyond the roughly 6k cycles the tests need
   initial begin
      #(60000 * 50);
      fail_count++;
      tally_and_finish();
   end
endmodule
`default_nettype wire
